/* rtl/pse_consts.svh */
`ifndef PSE_CONSTS_SVH
`define PSE_CONSTS_SVH
// ----------------------------------------
// Command codes of the register range
// ----------------------------------------
`define CMD_RESET 8'h1A
`define CMD_LEGACY 8'h20
`define CMD_TWO_EVENT 8'h21
`define CMD_DEFER 8'h27
`define CMD_DISC_TH 8'h29
// ----------------------------------------
// Reset command bit positions
// ----------------------------------------
`define RST_CLEAR_ALL 7
`define RST_ALERT_ONLY 6
`define RST_SOFT 4
`define RST_PORT_LSB 0
// ----------------------------------------
// Reset values
// ----------------------------------------
`define LEGACY_RST 8'h00
`define TWO_EVENT_RST 8'hAA
`define DEFER_RST 8'h00
`define DISC_TH_RST 8'h00
// ----------------------------------------
// Timing figures
// ----------------------------------------
`define CLK_PERIOD_NS 25
`define DEFER_STEP_MS 10
`define NS_PER_MS 1000000
`define DEFER_STEP_CYCLES (`DEFER_STEP_MS * `NS_PER_MS / `CLK_PERIOD_NS)
`define MS_TICK_CYCLES (`NS_PER_MS / `CLK_PERIOD_NS)
`define MPDO_00_MS 11'd360
`define MPDO_01_MS 11'd90
`define MPDO_10_MS 11'd180
`define MPDO_11_MS 11'd720
`define RESTART_PCT 14'd13
`define PCT_DIV 14'd100
// ----------------------------------------
// Disconnect thresholds in half milliamps
// ----------------------------------------
`define DTH_00_HMA 7'd15
`define DTH_01_HMA 7'd30
`define DTH_10_HMA 7'd60
`define DTH_11_HMA 7'd100
`endif

/* rtl/pse_pkg.sv */
package pse_pkg;
  typedef enum logic [1:0] {
    MODE_OFF = 2'h0,
    MODE_MANUAL = 2'h1,
    MODE_SEMI = 2'h3,
    MODE_AUTO = 2'h2
  } op_mode_t;
  typedef enum logic [1:0] {
    PROBE_STANDARD = 2'h0,
    PROBE_LEGACY = 2'h1,
    PROBE_BOTH = 2'h2,
    PROBE_RSVD = 2'h3
  } probe_sel_t;
endpackage

/* rtl/pse_port_control_regs.sv */
`timescale 1ns/100ps
`include "pse_consts.svh"
// Operation
// RULE_01: Reset command bits act once when written one; zeros do nothing; nothing stored.
// RULE_02: clear_all_events clears every event and interrupt bit and releases the alert pin.
// RULE_03: alert_release_only releases the alert pin, leaving events and interrupts alone.
// RULE_04: full_soft_reset returns the device to its power-up state.
// RULE_05: After soft reset, supply-low events show the present supply condition.
// RULE_06: port_force_off turns its own port off at once in any mode.
// RULE_07: Port reset clears voltage, status, class, probe, enable and fault bits of that port.
// RULE_08: Port reset during cool-down cancels the cool-down lockout.
// RULE_09: Port reset of a powered port shuts it, sets change bits, clears status bits.
// RULE_10: Legacy detection runs on probe restart, or in semi-auto/auto while probing enabled.
// RULE_11: In semi-auto or auto, a legacy device is never powered automatically.
// RULE_12: old_pd_probe_select picks standard, legacy only, or standard then legacy.
// RULE_13: Two-event classification applies per mode after a class 4 result.
// RULE_14: dual_class_select 00 disables, 01 or 11 enable the second class event.
// RULE_15: Non-zero alert_defer_period N runs a timer of period N times 10 ms.
// RULE_16: Non-critical interrupts pass only when the timer hits zero, then it reloads.
// RULE_17: alert_defer_period zero disables deferral; interrupts pass at once.
// RULE_18: Reading alert_defer_period returns the value last written.
// RULE_19: Host keeps the upper four bits of the timer register at reset value.
// RULE_20: Powered port below threshold starts disconnect timer; expiry powers the port down.
// RULE_21: drop_threshold_select gives 7.5, 15, 30 or 50 mA.
// RULE_22: Disconnect timer restarts after current above threshold for 13% of delay; floors at zero.
// RULE_23: Alert pin asserts only while alert_output_gate is one; events unaffected.
// RULE_24: Critical interrupts bypass the deferral timer.
module pse_port_control_regs #(
  parameter int unsigned DEFER_STEP_CYCLES = `DEFER_STEP_CYCLES,
  parameter int unsigned MS_TICK_CYCLES = `MS_TICK_CYCLES
) (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic cmd_wr_pulse,
  input wire logic cmd_rd_pulse,
  input wire logic [7:0] cmd_code,
  input wire logic [7:0] cmd_wdata,
  input wire pse_pkg::op_mode_t op_mode,
  input wire logic [3:0] signature_probe_enable,
  input wire logic [3:0] class_enable,
  input wire logic [3:0] probe_restart_push,
  input wire logic [3:0] class_restart_push,
  input wire logic [3:0] port_on_push,
  input wire logic [3:0] legacy_found,
  input wire logic [3:0] class4_found,
  input wire logic [3:0] port_powered,
  input wire logic [3:0] port_cooldown,
  input wire logic [3:0] port_below_thresh,
  input wire logic [7:0] disconnect_delay_sel,
  input wire logic [7:0] noncrit_irq_in,
  input wire logic [7:0] crit_irq_in,
  input wire logic [7:0] irq_mask_in,
  input wire logic alert_output_gate,
  input wire logic logic_supply_ok_pin,
  input wire logic main_supply_ok_pin,
  output logic [7:0] cmd_rdata,
  output logic host_alert_n,
  output logic [7:0] int_status,
  output logic logic_supply_low_event,
  output logic main_supply_low_event,
  output logic clear_events_pulse,
  output logic soft_reset_pulse,
  output logic [3:0] port_force_off,
  output logic [3:0] port_clear_pulse,
  output logic [3:0] cooldown_cancel,
  output logic [3:0] power_change_set,
  output logic [3:0] port_drop,
  output logic [3:0] legacy_run_req,
  output logic [3:0] auto_power_block,
  output logic [3:0] second_class_req,
  output logic [7:0] old_pd_probe_select,
  output logic [7:0] dual_class_select,
  output logic [27:0] drop_threshold_hma
);

  // ----------------------------------------
  // Helper functions
  // ----------------------------------------

  // Returns the programmed disconnect delay in milliseconds.
  function automatic logic [10:0] mpdo_ms(input logic [1:0] sel);
    unique case (sel)
      2'h0: mpdo_ms = `MPDO_00_MS;
      2'h1: mpdo_ms = `MPDO_01_MS;
      2'h2: mpdo_ms = `MPDO_10_MS;
      2'h3: mpdo_ms = `MPDO_11_MS;
    endcase
  endfunction

  // Returns the nominal disconnect threshold in half milliamps.
  function automatic logic [6:0] thresh_hma(input logic [1:0] sel);
    unique case (sel)
      2'h0: thresh_hma = `DTH_00_HMA;
      2'h1: thresh_hma = `DTH_01_HMA;
      2'h2: thresh_hma = `DTH_10_HMA;
      2'h3: thresh_hma = `DTH_11_HMA;
    endcase
  endfunction

  // ----------------------------------------
  // Command decode
  // ----------------------------------------
  logic reset_wr;
  logic soft_rst;
  logic clear_all;
  logic alert_only;
  logic any_rst;
  logic [3:0] port_rst;
  logic [7:0] legacy_reg;
  logic [7:0] two_event_reg;
  logic [7:0] defer_reg;
  logic [7:0] disc_th_reg;

  // Reset command bits are decoded straight from the write strobe and never stored.
  assign reset_wr = cmd_wr_pulse && (cmd_code == `CMD_RESET); // see RULE_01
  assign soft_rst = reset_wr && cmd_wdata[`RST_SOFT]; // see RULE_04
  assign clear_all = reset_wr && cmd_wdata[`RST_CLEAR_ALL]; // see RULE_02
  assign alert_only = reset_wr && cmd_wdata[`RST_ALERT_ONLY]; // see RULE_03
  assign port_rst = reset_wr ? cmd_wdata[`RST_PORT_LSB +: 4] : 4'h0; // see RULE_06
  assign any_rst = sys_rst || soft_rst; // see RULE_04

  // ----------------------------------------
  // Read/write registers
  // ----------------------------------------

  // Writable registers; a soft reset loads the power-up values.
  always_ff @(posedge mclk) begin
    if (any_rst) begin
      legacy_reg <= `LEGACY_RST;
      two_event_reg <= `TWO_EVENT_RST;
      defer_reg <= `DEFER_RST; // see RULE_19
      disc_th_reg <= `DISC_TH_RST;
    end else if (cmd_wr_pulse) begin
      if (cmd_code == `CMD_LEGACY) begin
        legacy_reg <= cmd_wdata;
      end
      if (cmd_code == `CMD_TWO_EVENT) begin
        two_event_reg <= cmd_wdata;
      end
      if (cmd_code == `CMD_DEFER) begin
        defer_reg <= cmd_wdata;
      end
      if (cmd_code == `CMD_DISC_TH) begin
        disc_th_reg <= cmd_wdata;
      end
    end
  end

  // Read data; the timer register shows the written value, never the count.
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      cmd_rdata <= 8'h00;
    end else if (cmd_rd_pulse) begin
      unique case (cmd_code)
        `CMD_LEGACY: cmd_rdata <= legacy_reg;
        `CMD_TWO_EVENT: cmd_rdata <= two_event_reg;
        `CMD_DEFER: cmd_rdata <= defer_reg; // see RULE_18
        `CMD_DISC_TH: cmd_rdata <= disc_th_reg;
        default: cmd_rdata <= 8'h00;
      endcase
    end
  end

  // ----------------------------------------
  // Push-button actions
  // ----------------------------------------

  // One-cycle action pulses toward the port engines.
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      clear_events_pulse <= 1'b0;
      soft_reset_pulse <= 1'b0;
      port_force_off <= 4'h0;
      port_clear_pulse <= 4'h0;
      cooldown_cancel <= 4'h0;
      power_change_set <= 4'h0;
    end else begin
      clear_events_pulse <= clear_all; // see RULE_02
      soft_reset_pulse <= soft_rst; // see RULE_04
      port_force_off <= port_rst; // see RULE_06
      port_clear_pulse <= port_rst; // see RULE_07
      cooldown_cancel <= port_rst & port_cooldown; // see RULE_08
      power_change_set <= port_rst & port_powered; // see RULE_09
    end
  end

  // ----------------------------------------
  // Supply-low events
  // ----------------------------------------
  logic [1:0] vdd_sync_reg;
  logic [1:0] vpwr_sync_reg;

  // Two-stage synchronisers for the supply monitors.
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      vdd_sync_reg <= 2'h3;
      vpwr_sync_reg <= 2'h3;
    end else begin
      vdd_sync_reg <= {vdd_sync_reg[0], logic_supply_ok_pin};
      vpwr_sync_reg <= {vpwr_sync_reg[0], main_supply_ok_pin};
    end
  end

  // Sticky low events; soft reset loads the present condition, set beats clear.
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      logic_supply_low_event <= 1'b0;
      main_supply_low_event <= 1'b0;
    end else if (soft_rst || clear_all) begin
      logic_supply_low_event <= !vdd_sync_reg[1]; // see RULE_05
      main_supply_low_event <= !vpwr_sync_reg[1]; // see RULE_05
    end else begin
      logic_supply_low_event <= logic_supply_low_event || !vdd_sync_reg[1];
      main_supply_low_event <= main_supply_low_event || !vpwr_sync_reg[1];
    end
  end

  // ----------------------------------------
  // Interrupt deferral
  // ----------------------------------------
  logic [18:0] step_cnt_reg;
  logic [3:0] period_cnt_reg;
  logic [7:0] pending_reg;
  logic defer_on;
  logic step_end;
  logic defer_fire;
  logic [7:0] deliver;

  assign defer_on = (defer_reg[3:0] != 4'h0); // see RULE_17
  assign step_end = (step_cnt_reg == 19'(DEFER_STEP_CYCLES - 1));
  assign defer_fire = step_end && (period_cnt_reg == 4'h1); // see RULE_16
  assign deliver = crit_irq_in | (defer_on ? (defer_fire ? pending_reg : 8'h00) : noncrit_irq_in); // see RULE_24

  // Free-running timer of N 10 ms steps; a write to the period restarts it.
  always_ff @(posedge mclk) begin
    if (any_rst || !defer_on || (cmd_wr_pulse && cmd_code == `CMD_DEFER)) begin
      step_cnt_reg <= 19'h0;
      period_cnt_reg <= (cmd_wr_pulse && cmd_code == `CMD_DEFER) ? cmd_wdata[3:0] : defer_reg[3:0];
    end else if (step_end) begin
      step_cnt_reg <= 19'h0;
      period_cnt_reg <= defer_fire ? defer_reg[3:0] : period_cnt_reg - 4'h1; // see RULE_15
    end else begin
      step_cnt_reg <= step_cnt_reg + 19'h1;
    end
  end

  // Held-back non-critical interrupts; new arrivals at a release wait for the next.
  always_ff @(posedge mclk) begin
    if (any_rst || !defer_on) begin
      pending_reg <= 8'h00;
    end else begin
      pending_reg <= ((defer_fire || clear_all) ? 8'h00 : pending_reg) | noncrit_irq_in; // see RULE_16
    end
  end

  // ----------------------------------------
  // Interrupt register and alert pin
  // ----------------------------------------
  logic alert_set;

  assign alert_set = alert_output_gate && ((deliver & irq_mask_in) != 8'h00); // see RULE_23

  // Sticky interrupt bits; a new delivery in the clearing cycle survives.
  always_ff @(posedge mclk) begin
    if (any_rst) begin
      int_status <= 8'h00;
    end else if (clear_all) begin
      int_status <= deliver; // see RULE_02
    end else begin
      int_status <= int_status | deliver; // see RULE_03
    end
  end

  // Active-low alert; an alert-only release leaves the interrupt bits untouched, a clear-all release clears them.
  always_ff @(posedge mclk) begin
    if (any_rst) begin
      host_alert_n <= 1'b1;
    end else if (alert_set) begin
      host_alert_n <= 1'b0; // see RULE_23
    end else if (clear_all || alert_only) begin
      host_alert_n <= 1'b1; // see RULE_03
    end
  end

  // ----------------------------------------
  // Detection and classification steering
  // ----------------------------------------
  logic auto_like;

  assign auto_like = (op_mode == pse_pkg::MODE_SEMI) || (op_mode == pse_pkg::MODE_AUTO);

  // Per-port requests derived from the probe and class selections.
  always_ff @(posedge mclk) begin
    if (any_rst) begin
      legacy_run_req <= 4'h0;
      auto_power_block <= 4'h0;
      second_class_req <= 4'h0;
      old_pd_probe_select <= `LEGACY_RST;
      dual_class_select <= `TWO_EVENT_RST;
    end else begin
      old_pd_probe_select <= legacy_reg; // see RULE_12
      dual_class_select <= two_event_reg; // see RULE_14
      for (int i = 0; i < 4; i++) begin
        legacy_run_req[i] <= ((legacy_reg[2*i +: 2] == pse_pkg::PROBE_LEGACY) ||
          (legacy_reg[2*i +: 2] == pse_pkg::PROBE_BOTH)) &&
          (probe_restart_push[i] || (auto_like && signature_probe_enable[i])); // see RULE_10
        auto_power_block[i] <= auto_like && legacy_found[i]; // see RULE_11
        second_class_req[i] <= class4_found[i] && two_event_reg[2*i] &&
          (((op_mode == pse_pkg::MODE_MANUAL) && (class_enable[i] || class_restart_push[i])) ||
          ((op_mode == pse_pkg::MODE_SEMI) && port_on_push[i]) ||
          (op_mode == pse_pkg::MODE_AUTO)); // see RULE_13
      end
    end
  end

  // ----------------------------------------
  // Disconnect thresholds and timers
  // ----------------------------------------
  logic [15:0] ms_cnt_reg;
  logic ms_tick;
  logic [10:0] dis_cnt_reg [4];
  logic [10:0] above_cnt_reg [4];

  assign ms_tick = (ms_cnt_reg == 16'(MS_TICK_CYCLES - 1));

  // Millisecond prescaler shared by all four disconnect timers.
  always_ff @(posedge mclk) begin
    if (any_rst || ms_tick) begin
      ms_cnt_reg <= 16'h0;
    end else begin
      ms_cnt_reg <= ms_cnt_reg + 16'h1;
    end
  end

  // Threshold codes for the current comparators.
  always_ff @(posedge mclk) begin
    if (any_rst) begin
      drop_threshold_hma <= 28'h0;
    end else begin
      for (int i = 0; i < 4; i++) begin
        drop_threshold_hma[7*i +: 7] <= thresh_hma(disc_th_reg[2*i +: 2]); // see RULE_21
      end
    end
  end

  // Per-port disconnect timers counting down in milliseconds while current is low.
  always_ff @(posedge mclk) begin
    if (any_rst) begin
      port_drop <= 4'h0;
      for (int i = 0; i < 4; i++) begin
        dis_cnt_reg[i] <= 11'h0;
        above_cnt_reg[i] <= 11'h0;
      end
    end else begin
      for (int i = 0; i < 4; i++) begin
        port_drop[i] <= 1'b0;
        if (!port_powered[i]) begin
          dis_cnt_reg[i] <= mpdo_ms(disconnect_delay_sel[2*i +: 2]);
          above_cnt_reg[i] <= 11'h0;
        end else if (ms_tick && port_below_thresh[i]) begin
          above_cnt_reg[i] <= 11'h0;
          if (dis_cnt_reg[i] > 11'h1) begin
            dis_cnt_reg[i] <= dis_cnt_reg[i] - 11'h1; // see RULE_20
          end else begin
            dis_cnt_reg[i] <= 11'h0; // see RULE_22
            port_drop[i] <= 1'b1; // see RULE_20
          end
        end else if (ms_tick) begin
          if ({3'h0, above_cnt_reg[i] + 11'h1} >=
              {3'h0, mpdo_ms(disconnect_delay_sel[2*i +: 2])} * `RESTART_PCT / `PCT_DIV) begin
            dis_cnt_reg[i] <= mpdo_ms(disconnect_delay_sel[2*i +: 2]); // see RULE_22
            above_cnt_reg[i] <= 11'h0;
          end else begin
            above_cnt_reg[i] <= above_cnt_reg[i] + 11'h1;
          end
        end
      end
    end
  end

endmodule

/* test/pse_port_control_regs_chk.sv */
`timescale 1ns/100ps
`include "pse_consts.svh"
// ------
// Port checker
// ------
module pse_port_control_regs_chk (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic cmd_wr_pulse,
  input wire logic [7:0] cmd_code,
  input wire logic [7:0] cmd_wdata,
  input wire logic [7:0] crit_irq_in,
  input wire logic [7:0] noncrit_irq_in,
  input wire logic [3:0] port_cooldown,
  input wire logic [3:0] port_powered,
  input wire logic alert_output_gate,
  input wire logic host_alert_n,
  input wire logic [7:0] int_status,
  input wire logic clear_events_pulse,
  input wire logic soft_reset_pulse,
  input wire logic [3:0] port_force_off,
  input wire logic [3:0] cooldown_cancel,
  input wire logic [3:0] power_change_set
);
  default clocking @(posedge mclk); endclocking
  default disable iff (sys_rst);
  // A push-button write, and one that does not also reset the whole device.
  sequence rst_wr;
    cmd_wr_pulse && cmd_code == `CMD_RESET;
  endsequence
  sequence port_wr;
    rst_wr ##0 !cmd_wdata[`RST_SOFT];
  endsequence
  clear_all_a: assert property (rst_wr ##0 cmd_wdata[7] |=> clear_events_pulse)
    else $error("clear pulse missing");
  soft_rst_a: assert property (rst_wr ##0 cmd_wdata[4] |=> soft_reset_pulse)
    else $error("soft reset pulse missing");
  no_push_a: assert property (!(cmd_wr_pulse && cmd_code == `CMD_RESET) |=>
    port_force_off == 4'h0 && !soft_reset_pulse && !clear_events_pulse) else $error("pulse without write");
  force_off_a: assert property (port_wr |=> port_force_off == $past(cmd_wdata[3:0]))
    else $error("force off wrong");
  cooldown_a: assert property (port_wr |=> cooldown_cancel == ($past(cmd_wdata[3:0]) & $past(port_cooldown)))
    else $error("cooldown cancel wrong");
  power_chg_a: assert property (port_wr |=> power_change_set == ($past(cmd_wdata[3:0]) & $past(port_powered)))
    else $error("power change wrong");
  alert_release_a: assert property (rst_wr ##0 (cmd_wdata[7:4] == 4'h4 && crit_irq_in == 8'h00
    && noncrit_irq_in == 8'h00) |=> host_alert_n && int_status == $past(int_status)) else $error("release wrong");
  gate_off_a: assert property (!alert_output_gate && host_alert_n |=> host_alert_n)
    else $error("alert while gated");
  crit_pass_a: assert property (crit_irq_in != 8'h00 && !cmd_wr_pulse |=>
    (int_status & $past(crit_irq_in)) == $past(crit_irq_in)) else $error("critical held back");
endmodule
bind pse_port_control_regs pse_port_control_regs_chk chk (.mclk, .sys_rst, .cmd_wr_pulse, .cmd_code, .cmd_wdata,
  .crit_irq_in, .noncrit_irq_in, .port_cooldown, .port_powered, .alert_output_gate, .host_alert_n, .int_status,
  .clear_events_pulse, .soft_reset_pulse, .port_force_off, .cooldown_cancel, .power_change_set);

/* test/pse_host_model.sv */
`timescale 1ns/100ps
// ------
// Host issuing command bytes
// ------
module pse_host_model (
  input wire logic mclk,
  input wire logic [7:0] cmd_rdata,
  output logic cmd_wr_pulse,
  output logic cmd_rd_pulse,
  output logic [7:0] cmd_code,
  output logic [7:0] cmd_wdata
);
  // Idle lines carry the inverse of the last byte, so no stale value looks valid.
  initial begin
    cmd_wr_pulse = 1'b0;
    cmd_rd_pulse = 1'b0;
    cmd_code = 8'hFF;
    cmd_wdata = 8'hFF;
  end
  // One write byte, taken at the edge after it is raised.
  task automatic wr(input logic [7:0] code, input logic [7:0] data);
    @(posedge mclk);
    cmd_wr_pulse <= 1'b1;
    cmd_code <= code;
    cmd_wdata <= data;
    @(posedge mclk);
    cmd_wr_pulse <= 1'b0;
    cmd_code <= ~code;
    cmd_wdata <= ~data;
    #1;
  endtask
  // One read byte; the answer stands after the taking edge.
  task automatic rd(input logic [7:0] code, output logic [7:0] data);
    @(posedge mclk);
    cmd_rd_pulse <= 1'b1;
    cmd_code <= code;
    @(posedge mclk);
    cmd_rd_pulse <= 1'b0;
    cmd_code <= ~code;
    #1;
    data = cmd_rdata;
  endtask
endmodule

/* test/test_pse_port_control_regs.sv */
`timescale 1ns/100ps
module test_pse_port_control_regs;
  logic mclk = 1'b0;
  logic sys_rst, alert_output_gate, logic_supply_ok_pin, main_supply_ok_pin;
  pse_pkg::op_mode_t op_mode;
  logic [3:0] signature_probe_enable, class_enable, probe_restart_push, class_restart_push, port_on_push;
  logic [3:0] legacy_found, class4_found, port_powered, port_cooldown, port_below_thresh;
  logic [7:0] disconnect_delay_sel, noncrit_irq_in, crit_irq_in, irq_mask_in;
  logic cmd_wr_pulse, cmd_rd_pulse, host_alert_n, logic_supply_low_event, main_supply_low_event;
  logic clear_events_pulse, soft_reset_pulse;
  logic [7:0] cmd_code, cmd_wdata, cmd_rdata, int_status, old_pd_probe_select, dual_class_select;
  logic [3:0] port_force_off, port_clear_pulse, cooldown_cancel, power_change_set;
  logic [3:0] port_drop, legacy_run_req, auto_power_block, second_class_req;
  logic [27:0] drop_threshold_hma;
  int n_errors = 0;
  int checked = 0;
  int n;
  logic [15:0] r = 16'h9860;
  logic [7:0] d;
  logic [7:0] codes [6] = '{8'h20, 8'h21, 8'h27, 8'h29, 8'h1A, 8'h55};
  logic [7:0] rv [6] = '{8'h00, 8'hAA, 8'h00, 8'h00, 8'h00, 8'h00};
  logic [7:0] tec [3] = '{8'h55, 8'hAA, 8'hFF};
  logic [3:0] tev [3] = '{4'hF, 4'h0, 4'hF};
  // ------
  // Design, host and clock
  // ------
  pse_port_control_regs #(.DEFER_STEP_CYCLES(20), .MS_TICK_CYCLES(10)) dut (.mclk, .sys_rst, .cmd_wr_pulse,
    .cmd_rd_pulse, .cmd_code, .cmd_wdata, .op_mode, .signature_probe_enable, .class_enable, .probe_restart_push,
    .class_restart_push, .port_on_push, .legacy_found, .class4_found, .port_powered, .port_cooldown,
    .port_below_thresh, .disconnect_delay_sel, .noncrit_irq_in, .crit_irq_in, .irq_mask_in, .alert_output_gate,
    .logic_supply_ok_pin, .main_supply_ok_pin, .cmd_rdata, .host_alert_n, .int_status, .logic_supply_low_event,
    .main_supply_low_event, .clear_events_pulse, .soft_reset_pulse, .port_force_off, .port_clear_pulse,
    .cooldown_cancel, .power_change_set, .port_drop, .legacy_run_req, .auto_power_block, .second_class_req,
    .old_pd_probe_select, .dual_class_select, .drop_threshold_hma);
  pse_host_model host (.mclk, .cmd_rdata, .cmd_wr_pulse, .cmd_rd_pulse, .cmd_code, .cmd_wdata);
  // Half period of the 40 MHz clock.
  always #12.5 mclk = ~mclk;
  // ------
  // Helpers
  // ------
  function automatic logic [15:0] nxt(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  // Thresholds in half milliamps, seven bits a port.
  function automatic logic [27:0] thr(input logic [7:0] v);
    for (int p = 0; p < 4; p++)
      thr[p*7 +: 7] = v[p*2 +: 2] == 2'h0 ? 7'h0F : v[p*2 +: 2] == 2'h1 ? 7'h1E : v[p*2 +: 2] == 2'h2 ? 7'h3C : 7'h64;
  endfunction
  task automatic cmp(input logic [27:0] got, input logic [27:0] exp);
    checked++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic conclude;
    if (n_errors == 0 && checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  // Cuts a hang short well beyond the expected run.
  initial begin
    repeat (20000) @(posedge mclk);
    n_errors++;
    conclude;
  end
  // ------
  // Main sequence
  // ------
  initial begin
    sys_rst = 1'b1;
    op_mode = pse_pkg::MODE_MANUAL;
    {signature_probe_enable, class_enable, probe_restart_push, class_restart_push, port_on_push} = '0;
    {legacy_found, class4_found, port_powered, port_cooldown, port_below_thresh} = '0;
    {disconnect_delay_sel, noncrit_irq_in, crit_irq_in} = '0;
    irq_mask_in = 8'hFF;
    {alert_output_gate, logic_supply_ok_pin, main_supply_ok_pin} = 3'h7;
    repeat (8) @(posedge mclk);
    sys_rst <= 1'b0;
    foreach (codes[i]) begin
      host.rd(codes[i], d);
      cmp(d, rv[i]);
    end
    host.wr(8'h29, 8'hE4);
    host.wr(8'h20, 8'hE4);
    cmp(drop_threshold_hma, thr(8'hE4));
    // Random register round trips.
    for (int i = 0; i < 20; i++) begin
      r = nxt(r);
      host.wr(8'h29, r[7:0]);
      host.wr(8'h21, r[15:8]);
      cmp(drop_threshold_hma, thr(r[7:0]));
      host.wr(8'h27, {4'h0, r[3:0]});
      cmp(dual_class_select, r[15:8]);
      host.rd(8'h27, d);
      cmp(d, {4'h0, r[3:0]});
    end
    host.wr(8'h27, 8'h00);
    // Probe selection per port: standard, legacy, both, reserved.
    host.wr(8'h20, 8'hE4);
    cmp(old_pd_probe_select, 8'hE4);
    @(posedge mclk);
    op_mode <= pse_pkg::MODE_AUTO;
    signature_probe_enable <= 4'hF;
    legacy_found <= 4'h5;
    repeat (3) @(posedge mclk);
    #1;
    cmp(legacy_run_req, 4'h6);
    cmp(auto_power_block, 4'h5);
    @(posedge mclk);
    op_mode <= pse_pkg::MODE_MANUAL;
    probe_restart_push <= 4'hF;
    @(posedge mclk);
    probe_restart_push <= 4'h0;
    #1;
    cmp(legacy_run_req, 4'h6);
    cmp(auto_power_block, 4'h0);
    repeat (2) @(posedge mclk);
    #1;
    cmp(legacy_run_req, 4'h0);
    // Engine activity of every kind with the second event switched off.
    host.wr(8'h21, 8'h00);
    for (int i = 0; i < 40; i++) begin
      r = nxt(r);
      @(posedge mclk);
      {class_enable, class_restart_push, port_on_push, class4_found} <= r;
      legacy_found <= r[15:12] ^ r[3:0];
      op_mode <= pse_pkg::op_mode_t'(r[9:8]);
      #1;
      cmp(second_class_req, 4'h0);
    end
    @(posedge mclk);
    {class_enable, class_restart_push, port_on_push, legacy_found} <= '0;
    class4_found <= 4'hF;
    op_mode <= pse_pkg::MODE_AUTO;
    foreach (tec[i]) begin
      host.wr(8'h21, tec[i]);
      repeat (2) @(posedge mclk);
      #1;
      cmp(second_class_req, tev[i]);
    end
    // Port resets with random cool-down and powered states.
    for (int i = 0; i < 8; i++) begin
      r = nxt(r);
      @(posedge mclk);
      port_cooldown <= r[3:0];
      port_powered <= r[7:4];
      host.wr(8'h1A, {4'h0, r[11:8]});
      cmp(port_force_off, r[11:8]);
      cmp(port_clear_pulse, r[11:8]);
      cmp(cooldown_cancel, r[11:8] & r[3:0]);
      cmp(power_change_set, r[11:8] & r[7:4]);
      @(posedge mclk);
      #1;
      cmp(port_force_off, 4'h0);
    end
    // Interrupts with deferral off, release, clear and gate.
    @(posedge mclk);
    {port_cooldown, port_powered} <= '0;
    noncrit_irq_in <= 8'h04;
    @(posedge mclk);
    noncrit_irq_in <= 8'h00;
    #1;
    cmp(int_status, 8'h04);
    cmp(host_alert_n, 1'b0);
    host.wr(8'h1A, 8'h40);
    cmp({int_status, host_alert_n}, 9'h009);
    host.wr(8'h1A, 8'h80);
    @(posedge mclk);
    alert_output_gate <= 1'b0;
    crit_irq_in <= 8'h01;
    #1;
    cmp(int_status, 8'h00);
    @(posedge mclk);
    crit_irq_in <= 8'h00;
    repeat (2) @(posedge mclk);
    #1;
    cmp({int_status, host_alert_n}, 9'h003);
    host.wr(8'h1A, 8'h80);
    alert_output_gate <= 1'b1;
    // Deferral of two steps: critical passes at once, the other waits.
    host.wr(8'h27, 8'h02);
    @(posedge mclk);
    noncrit_irq_in <= 8'h10;
    crit_irq_in <= 8'h01;
    @(posedge mclk);
    {noncrit_irq_in, crit_irq_in} <= '0;
    #1;
    cmp(int_status, 8'h01);
    n = 0;
    while (int_status[4] !== 1'b1 && n < 60) begin
      @(posedge mclk);
      #1;
      n++;
    end
    cmp(n > 30 && n < 45, 1'b1);
    host.wr(8'h27, 8'h00);
    host.wr(8'h1A, 8'h80);
    // Soft reset while the main supply is low.
    host.wr(8'h20, 8'h55);
    main_supply_ok_pin <= 1'b0;
    disconnect_delay_sel <= 8'h09;
    repeat (4) @(posedge mclk);
    host.wr(8'h1A, 8'h10);
    @(posedge mclk);
    #1;
    cmp({main_supply_low_event, logic_supply_low_event}, 2'h2);
    cmp({old_pd_probe_select, dual_class_select}, 16'h00AA);
    // Disconnect after 90 ms of low current on port 0.
    @(posedge mclk);
    main_supply_ok_pin <= 1'b1;
    port_powered <= 4'h3;
    port_below_thresh <= 4'h3;
    n = 0;
    while (port_drop[0] !== 1'b1 && n < 1000) begin
      @(posedge mclk);
      #1;
      n++;
    end
    cmp(n > 880 && n < 920, 1'b1);
    // Port 1 (180 ms) goes above for 15 ms, short of its 23 ms window, so its count survives.
    @(posedge mclk);
    port_below_thresh <= 4'h1;
    repeat (150) @(posedge mclk);
    port_below_thresh <= 4'h3;
    n = 0;
    while (port_drop[1] !== 1'b1 && n < 1000) begin
      @(posedge mclk);
      #1;
      n++;
    end
    cmp(n > 880 && n < 920, 1'b1);
    conclude;
  end
endmodule
